// ### rtl/rx_filter_defs.svh
// register offsets, field positions, reset values and timing for the receive type filter
`ifndef RX_FILTER_DEFS_SVH
`define RX_FILTER_DEFS_SVH
`define ADDR_FRAME_TYPE_FILTER_CFG 7'h01
`define ADDR_SOURCE_MATCH_CONTROL 7'h02
`define ADDR_SHORT_MATCH_ENABLE_LOW 7'h04
`define ADDR_SHORT_MATCH_ENABLE_MID 7'h05
`define ADDR_SHORT_MATCH_ENABLE_HIGH 7'h06
`define ADDR_FILTER_CONTROL 7'h10
`define ADDR_LONG_MATCH_ENABLE_LOW 7'h11
`define ADDR_LONG_MATCH_ENABLE_MID 7'h12
`define ADDR_LONG_MATCH_ENABLE_HIGH 7'h13
`define ADDR_SHORT_PENDING_LOW 7'h14
`define ADDR_SHORT_PENDING_MID 7'h15
`define ADDR_SHORT_PENDING_HIGH 7'h16
`define ADDR_LONG_PENDING_LOW 7'h17
`define ADDR_LONG_PENDING_MID 7'h18
`define ADDR_LONG_PENDING_HIGH 7'h19
`define ADDR_FILTER_STATUS 7'h1A
`define RST_FRAME_TYPE_FILTER_CFG 8'h78
`define RST_SOURCE_MATCH_CONTROL 8'h07
`define RST_FILTER_CONTROL 8'h01
`define RST_ZERO_BYTE 8'h00
`define BIT_ACCEPT_RESERVED 7
`define BIT_ACCEPT_COMMAND 6
`define BIT_ACCEPT_ACK 5
`define BIT_ACCEPT_PAYLOAD 4
`define BIT_ACCEPT_BEACON 3
`define BIT_MOD_HI 2
`define BIT_MOD_LO 1
`define BIT_PEND_REQ_ONLY 2
`define BIT_AUTO_PEND 1
`define BIT_SRC_MATCH 0
`define BIT_FILTER_EN 0
`define MASK_FILTER_CFG 8'hFE
`define MASK_SRC_CTRL 8'h07
`define MASK_FILTER_CTRL 8'h01
`define FT_BEACON 3'h0
`define FT_DATA 3'h1
`define FT_ACK 3'h2
`define FT_COMMAND 3'h3
`define MOD_KEEP 2'h0
`define MOD_INVERT 2'h1
`define MOD_CLEAR 2'h2
`define MOD_SET 2'h3
`define DATA_REQUEST_ID 8'h04
`define MATCH_ENTRIES 24
`define MATCH_WAIT_CYCLES 2
`endif

// ### rtl/rx_filter_pkg.sv
// types shared by the receive type filter files
package rx_filter_pkg;
  // one frame decision request from the receive path
  typedef struct packed {
    logic valid;
    logic [15:0] frame_control;
    logic [7:0] command_id;
    logic src_is_long;
    logic [4:0] match_index;
    logic match_hit;
  } frame_req_t;
  // decision returned for the frame
  typedef struct packed {
    logic valid;
    logic accept;
    logic pending;
    logic [15:0] fifo_control;
  } frame_res_t;
  // register port carrier
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOOKUP = 3'b010,
    ST_DONE = 3'b100
  } dec_state_t;
endpackage : rx_filter_pkg

// ### rtl/rx_match_enable_mem.sv
// table of per-entry enable and pending bits with registered lookup
`timescale 1ns/1ps
`default_nettype none
`include "rx_filter_defs.svh"
module rx_match_enable_mem (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_wr_sel, // 0 short en, 1 long en, 2 short pend, 3 long pend
  input wire logic [1:0] i_wr_byte,
  input wire logic i_wr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_lk_long,
  input wire logic [4:0] i_lk_index,
  output logic o_lk_enabled,
  output logic [95:0] o_words
);
  // all four 24-bit words packed together
  typedef struct packed {
    logic [3:0][23:0] word;
    logic lk;
  } mem_state_t;
  mem_state_t s_q;
  mem_state_t s_d;
  // byte writes go into one word lane, lookup reads enable and pending together
  always_comb begin
    s_d = s_q;
    for (int w = 0; w < 4; w++) begin
      for (int b = 0; b < 3; b++) begin
        if (i_wr && i_wr_sel == w[1:0] && i_wr_byte == b[1:0]) begin
          s_d.word[w][b*8 +: 8] = i_wr_data;
        end
      end
    end
    if (i_lk_index >= 5'd24) begin
      s_d.lk = 1'b0;
    end else if (i_lk_long) begin
      s_d.lk = s_q.word[1][i_lk_index] & s_q.word[3][i_lk_index]; // [R11]
    end else begin
      s_d.lk = s_q.word[0][i_lk_index] & s_q.word[2][i_lk_index]; // [R11] [R13]
    end
  end
  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_lk_enabled = s_q.lk;
  assign o_words = s_q.word;
endmodule : rx_match_enable_mem
`default_nettype wire

// ### rtl/rx_frame_type_filter_auto_pending_enable.sv
// frame type filter, type modifier and automatic pending decision
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rx_filter_defs.svh"
// Functional notes
// [R1] reserved types rejected unless accept set
// [R2] command frames gated by command accept
// [R3] ack frames gated by ack accept
// [R4] data frames gated by payload accept
// [R5] beacon frames gated by beacon accept
// [R6] modifier alters type msb before filtering
// [R7] fifo keeps original type field
// [R8] software writes reserved bits zero
// [R9] auto pending needs filter, match, auto_pending_enable
// [R10] request-only also needs data request command
// [R11] match needs entry enable and pending
// [R12] matching only when match enable set
// [R13] 24-bit short enable in three bytes
// [R14] software clears enable while rewriting entry
// [R15] filter disabled ignores all these settings
// [R16] type taken from control field low bits
// [R17] otherwise pending flag stays cleared
module rx_frame_type_filter_auto_pending_enable (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire rx_filter_pkg::frame_req_t i_frame,
  output rx_filter_pkg::frame_res_t o_result,
  output logic o_busy
);
  // all block state
  typedef struct packed {
    logic [7:0] type_cfg;
    logic [7:0] src_ctrl;
    logic [7:0] filt_ctrl;
    logic [7:0] rdata;
    rx_filter_pkg::dec_state_t state;
    logic [1:0] wait_cnt;
    logic [15:0] fc;
    logic accept;
    logic pend_cand;
    logic busy;
    rx_filter_pkg::frame_res_t res;
    logic [7:0] accepted_cnt;
    logic [7:0] rejected_cnt;
  } top_state_t;
  top_state_t s_q;
  top_state_t s_d;
  logic lk_enabled;
  logic [95:0] words;
  logic tbl_wr;
  logic [1:0] tbl_sel;
  logic [1:0] tbl_byte;
  logic [2:0] raw_type;
  logic [2:0] mod_type;
  logic type_ok;
  logic filter_on;
  logic pend_ok;
  // table write decode: offsets map to word lane and byte
  // lanes: 0 short enable, 1 long enable, 2 short pending, 3 long pending
  // the byte index gives the low byte the lowest offset of each word
  always_comb begin
    tbl_wr = 1'b0;
    tbl_sel = 2'h0;
    tbl_byte = 2'h0;
    case (i_addr)
      // short entry enable word, one bit per entry
      `ADDR_SHORT_MATCH_ENABLE_LOW: begin
        tbl_wr = i_wr; // [R13]
        tbl_sel = 2'h0;
        tbl_byte = 2'h0;
      end
      `ADDR_SHORT_MATCH_ENABLE_MID: begin
        tbl_wr = i_wr; // [R13]
        tbl_sel = 2'h0;
        tbl_byte = 2'h1;
      end
      `ADDR_SHORT_MATCH_ENABLE_HIGH: begin
        tbl_wr = i_wr; // [R13]
        tbl_sel = 2'h0;
        tbl_byte = 2'h2;
      end
      // long entry enable word, plain read and write
      `ADDR_LONG_MATCH_ENABLE_LOW: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h1;
        tbl_byte = 2'h0;
      end
      `ADDR_LONG_MATCH_ENABLE_MID: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h1;
        tbl_byte = 2'h1;
      end
      `ADDR_LONG_MATCH_ENABLE_HIGH: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h1;
        tbl_byte = 2'h2;
      end
      // short entry pending word
      `ADDR_SHORT_PENDING_LOW: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h2;
        tbl_byte = 2'h0;
      end
      `ADDR_SHORT_PENDING_MID: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h2;
        tbl_byte = 2'h1;
      end
      `ADDR_SHORT_PENDING_HIGH: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h2;
        tbl_byte = 2'h2;
      end
      // long entry pending word
      `ADDR_LONG_PENDING_LOW: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h3;
        tbl_byte = 2'h0;
      end
      `ADDR_LONG_PENDING_MID: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h3;
        tbl_byte = 2'h1;
      end
      `ADDR_LONG_PENDING_HIGH: begin
        tbl_wr = i_wr;
        tbl_sel = 2'h3;
        tbl_byte = 2'h2;
      end
      // any other offset leaves the table alone
      default: begin
        tbl_wr = 1'b0;
      end
    endcase
  end
  // enable and pending bit table
  rx_match_enable_mem u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_sel(tbl_sel),
    .i_wr_byte(tbl_byte),
    .i_wr(tbl_wr),
    .i_wr_data(i_wdata),
    .i_lk_long(i_frame.src_is_long),
    .i_lk_index(i_frame.match_index),
    .o_lk_enabled(lk_enabled),
    .o_words(words)
  );
  // type extraction, modification and per-type acceptance
  always_comb begin
    filter_on = s_q.filt_ctrl[`BIT_FILTER_EN];
    raw_type = i_frame.frame_control[2:0]; // [R16]
    mod_type = raw_type;
    case (s_q.type_cfg[`BIT_MOD_HI:`BIT_MOD_LO])
      `MOD_KEEP: mod_type[2] = raw_type[2]; // [R6]
      `MOD_INVERT: mod_type[2] = ~raw_type[2]; // [R6]
      `MOD_CLEAR: mod_type[2] = 1'b0; // [R6]
      `MOD_SET: mod_type[2] = 1'b1; // [R6]
      default: mod_type[2] = raw_type[2];
    endcase
    if (mod_type[2]) begin
      type_ok = s_q.type_cfg[`BIT_ACCEPT_RESERVED]; // [R1]
    end else begin
      case (mod_type)
        `FT_COMMAND: type_ok = s_q.type_cfg[`BIT_ACCEPT_COMMAND]; // [R2]
        `FT_ACK: type_ok = s_q.type_cfg[`BIT_ACCEPT_ACK]; // [R3]
        `FT_DATA: type_ok = s_q.type_cfg[`BIT_ACCEPT_PAYLOAD]; // [R4]
        `FT_BEACON: type_ok = s_q.type_cfg[`BIT_ACCEPT_BEACON]; // [R5]
        default: type_ok = 1'b0;
      endcase
    end
    // pending candidate from controls and command check, table hit joins later
    pend_ok = filter_on // [R9]
      & s_q.src_ctrl[`BIT_SRC_MATCH] // [R12]
      & s_q.src_ctrl[`BIT_AUTO_PEND] // [R9]
      & i_frame.match_hit
      & (~s_q.src_ctrl[`BIT_PEND_REQ_ONLY]
         | (raw_type == `FT_COMMAND && i_frame.command_id == `DATA_REQUEST_ID)); // [R10]
  end
  // registers, read port and decision sequence
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.res.valid = 1'b0;
    if (i_wr) begin
      case (i_addr)
        `ADDR_FRAME_TYPE_FILTER_CFG: s_d.type_cfg = i_wdata & `MASK_FILTER_CFG; // [R8]
        `ADDR_SOURCE_MATCH_CONTROL: s_d.src_ctrl = i_wdata & `MASK_SRC_CTRL; // [R8]
        `ADDR_FILTER_CONTROL: s_d.filt_ctrl = i_wdata & `MASK_FILTER_CTRL;
        default: s_d.filt_ctrl = s_q.filt_ctrl;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `ADDR_FRAME_TYPE_FILTER_CFG: s_d.rdata = s_q.type_cfg;
        `ADDR_SOURCE_MATCH_CONTROL: s_d.rdata = s_q.src_ctrl;
        `ADDR_SHORT_MATCH_ENABLE_LOW: s_d.rdata = words[7:0];
        `ADDR_SHORT_MATCH_ENABLE_MID: s_d.rdata = words[15:8];
        `ADDR_SHORT_MATCH_ENABLE_HIGH: s_d.rdata = words[23:16];
        `ADDR_FILTER_CONTROL: s_d.rdata = s_q.filt_ctrl;
        `ADDR_LONG_MATCH_ENABLE_LOW: s_d.rdata = words[31:24];
        `ADDR_LONG_MATCH_ENABLE_MID: s_d.rdata = words[39:32];
        `ADDR_LONG_MATCH_ENABLE_HIGH: s_d.rdata = words[47:40];
        `ADDR_SHORT_PENDING_LOW: s_d.rdata = words[55:48];
        `ADDR_SHORT_PENDING_MID: s_d.rdata = words[63:56];
        `ADDR_SHORT_PENDING_HIGH: s_d.rdata = words[71:64];
        `ADDR_LONG_PENDING_LOW: s_d.rdata = words[79:72];
        `ADDR_LONG_PENDING_MID: s_d.rdata = words[87:80];
        `ADDR_LONG_PENDING_HIGH: s_d.rdata = words[95:88];
        `ADDR_FILTER_STATUS: s_d.rdata = {s_q.accepted_cnt[3:0], s_q.rejected_cnt[3:0]};
        default: s_d.rdata = 8'h00;
      endcase
    end
    case (s_q.state)
      rx_filter_pkg::ST_IDLE: begin
        // frame taken only when idle; capture decision inputs
        if (i_frame.valid) begin
          s_d.fc = i_frame.frame_control; // [R7]
          s_d.accept = filter_on ? type_ok : 1'b1; // [R15]
          s_d.pend_cand = pend_ok;
          s_d.busy = 1'b1;
          s_d.wait_cnt = 2'(`MATCH_WAIT_CYCLES - 1);
          s_d.state = rx_filter_pkg::ST_LOOKUP;
        end
      end
      rx_filter_pkg::ST_LOOKUP: begin
        // the lookup register follows the live index, which the receive path
        // may change after the take, so its bit is captured in the first cycle
        if (s_q.wait_cnt == 2'h0) begin
          // publish result; fifo copy is the unmodified control field
          s_d.res.valid = 1'b1;
          s_d.res.accept = s_q.accept;
          s_d.res.pending = s_q.pend_cand; // [R11] [R17]
          s_d.res.fifo_control = s_q.fc; // [R7]
          s_d.state = rx_filter_pkg::ST_DONE;
        end else begin
          if (s_q.wait_cnt == 2'(`MATCH_WAIT_CYCLES - 1)) begin
            s_d.pend_cand = s_q.pend_cand & lk_enabled; // [R11]
          end
          s_d.wait_cnt = s_q.wait_cnt - 2'h1;
        end
      end
      rx_filter_pkg::ST_DONE: begin
        // busy drops here, so a frame offered in this cycle is refused
        if (s_q.accept) begin
          s_d.accepted_cnt = s_q.accepted_cnt + 8'h01;
        end else begin
          s_d.rejected_cnt = s_q.rejected_cnt + 8'h01;
        end
        s_d.busy = 1'b0;
        s_d.state = rx_filter_pkg::ST_IDLE;
      end
      default: begin
        s_d.state = rx_filter_pkg::ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end
  // state register with documented reset values
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.type_cfg <= `RST_FRAME_TYPE_FILTER_CFG;
      s_q.src_ctrl <= `RST_SOURCE_MATCH_CONTROL;
      s_q.filt_ctrl <= `RST_FILTER_CONTROL;
      s_q.state <= rx_filter_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_rdata = s_q.rdata;
  assign o_result = s_q.res;
  assign o_busy = s_q.busy;
endmodule : rx_frame_type_filter_auto_pending_enable
`default_nettype wire

// ### tb/rx_frame_source.sv
// model of the demodulator handing received frames to the filter
`timescale 1ns/1ps
`default_nettype none
module rx_frame_source (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [15:0] i_fc,
  input wire logic [7:0] i_cmd,
  input wire logic [4:0] i_idx,
  input wire logic i_hit,
  output rx_filter_pkg::frame_req_t o_frame
);
  // one-cycle frame offer; between offers the fields flip so stale data never looks valid
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_frame <= '0;
    end else if (i_go) begin
      o_frame <= {1'b1, i_fc, i_cmd, 1'b0, i_idx, i_hit};
    end else begin
      o_frame <= {1'b0, ~o_frame[30:0]};
    end
  end
endmodule : rx_frame_source
`default_nettype wire

// ### tb/rx_filter_checker.sv
// timing and decision assertions at the filter ports
`timescale 1ns/1ps
`default_nettype none
module rx_filter_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire rx_filter_pkg::frame_req_t i_frame,
  input wire rx_filter_pkg::frame_res_t o_result,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] cfg_q; // shadow of the type filter settings
  logic [7:0] sm_q; // shadow of source match control
  logic fen_q; // shadow of global filter enable
  logic [2:0] mt; // type after modifier
  logic [3:0] en;
  logic acc; // expected accept
  logic tk; // frame taken this edge
  logic [2:0] ft;
  // follow register writes so the expectations track software
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= 8'h78;
      sm_q <= 8'h07;
      fen_q <= 1'b1;
    end else if (i_wr) begin
      if (i_addr == 7'h01) cfg_q <= i_wdata;
      if (i_addr == 7'h02) sm_q <= i_wdata;
      if (i_addr == 7'h10) fen_q <= i_wdata[0];
    end
  end
  // expected accept from modified type
  always_comb begin
    ft = i_frame.frame_control[2:0];
    tk = i_frame.valid && !o_busy;
    en = cfg_q[6:3];
    case (cfg_q[2:1])
      2'h1: mt = {~ft[2], ft[1:0]};
      2'h2: mt = {1'b0, ft[1:0]};
      2'h3: mt = {1'b1, ft[1:0]};
      default: mt = ft;
    endcase
    acc = !fen_q || (mt[2] ? cfg_q[7] : en[mt[1:0]]);
  end
  property p_busy; tk |=> o_busy [*3] ##1 !o_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy window wrong");
  property p_lat; tk |-> ##3 o_result.valid; endproperty
  a_lat: assert property (p_lat) else $error("result late");
  property p_cause; o_result.valid |-> $past(tk, 3); endproperty
  a_cause: assert property (p_cause) else $error("result without frame");
  property p_fifo;
    tk |-> ##3 o_result.fifo_control == $past(i_frame.frame_control, 3);
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo type altered");
  property p_acc; tk |-> ##3 o_result.accept == $past(acc, 3); endproperty
  a_acc: assert property (p_acc) else $error("accept wrong");
  property p_pen; tk && !(fen_q && sm_q[0] && sm_q[1]) |-> ##3 !o_result.pending; endproperty
  a_pen: assert property (p_pen) else $error("pending while disabled");
  property p_req;
    tk && sm_q[2] && !(ft == 3'h3 && i_frame.command_id == 8'h04) |-> ##3 !o_result.pending;
  endproperty
  a_req: assert property (p_req) else $error("pending without request");
  property p_hit; tk && !i_frame.match_hit |-> ##3 !o_result.pending; endproperty
  a_hit: assert property (p_hit) else $error("pending without match");
  property p_rd; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule : rx_filter_checker
bind rx_frame_type_filter_auto_pending_enable rx_filter_checker rx_filter_checker_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_frame(i_frame), .o_result(o_result), .o_busy(o_busy)
);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the receive type filter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, go = 0, hit = 0;
  logic [6:0] i_addr = 7'h00;
  logic [7:0] i_wdata = 8'h00, o_rdata, cmd = 8'h00;
  logic [15:0] fc = 16'h0000;
  logic [4:0] idx = 5'h00;
  rx_filter_pkg::frame_req_t frame;
  rx_filter_pkg::frame_res_t o_result;
  logic o_busy;
  int bad_count = 0, compares = 0, cyc = 0, n;
  // rows: {type cfg, frame type, accept}
  logic [11:0] rows [17] = '{12'h781, 12'h783, 12'h785, 12'h787, 12'h788, 12'h78A, 12'h78C,
    12'h78E, 12'hF8B, 12'h700, 12'h682, 12'h584, 12'h386, 12'h7A2, 12'h7AB, 12'h7CD, 12'h7E0};
  always #2.5 i_clk = ~i_clk;
  rx_frame_source rx_frame_source_inst (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_fc(fc),
    .i_cmd(cmd), .i_idx(idx), .i_hit(hit), .o_frame(frame));
  rx_frame_type_filter_auto_pending_enable rx_frame_type_filter_auto_pending_enable_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_frame(frame), .o_result(o_result), .o_busy(o_busy));
  task summarize;
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // compare seen against expected
  task chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge i_clk) {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd
  // offer one frame and check the decision
  task send(input logic [15:0] f, input logic [7:0] c, input logic [4:0] x, input logic h,
            input logic ea, input logic ep);
    @(posedge i_clk) {fc, cmd, idx, hit, go} <= {f, c, x, h, 1'b1};
    @(posedge i_clk) go <= 1'b0;
    for (n = 0; n < 8 && o_result.valid !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk(o_busy, 1'b1);
    chk(o_result.accept, ea);
    chk(o_result.pending, ep);
    chk(o_result.fifo_control, f);
  endtask : send
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(7'h01, 8'h78);
    rd(7'h02, 8'h07);
    rd(7'h04, 8'h00);
    rd(7'h7F, 8'h00);
    foreach (rows[i]) begin
      wr(7'h01, rows[i][11:4]);
      send({13'h1A5A, rows[i][3:1]}, 8'h04, 5'h11, 1'b0, rows[i][0], 1'b0);
    end
    wr(7'h01, 8'h78);
    wr(7'h04, 8'h5A);
    wr(7'h05, 8'hC3);
    wr(7'h06, 8'h02);
    rd(7'h05, 8'hC3);
    rd(7'h06, 8'h02);
    wr(7'h16, 8'h02);
    send(16'h8843, 8'h04, 5'h11, 1'b1, 1'b1, 1'b1);
    send(16'h8843, 8'h05, 5'h11, 1'b1, 1'b1, 1'b0);
    wr(7'h02, 8'h03);
    send(16'h8841, 8'h00, 5'h11, 1'b1, 1'b1, 1'b1);
    send(16'h8841, 8'h00, 5'h11, 1'b0, 1'b1, 1'b0);
    send(16'h8841, 8'h00, 5'h10, 1'b1, 1'b1, 1'b0);
    send(16'h8841, 8'h00, 5'h01, 1'b1, 1'b1, 1'b0);
    wr(7'h02, 8'h02);
    send(16'h8841, 8'h00, 5'h11, 1'b1, 1'b1, 1'b0);
    wr(7'h02, 8'h01);
    send(16'h8841, 8'h00, 5'h11, 1'b1, 1'b1, 1'b0);
    wr(7'h02, 8'h03);
    wr(7'h06, 8'h00);
    send(16'h8841, 8'h00, 5'h11, 1'b1, 1'b1, 1'b0);
    wr(7'h06, 8'h02);
    wr(7'h10, 8'h00);
    send(16'h8847, 8'h00, 5'h11, 1'b1, 1'b1, 1'b0);
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(7'h10, 8'h01);
    rd(7'h02, 8'h07);
    rd(7'h06, 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire
